// *** common/lss_pkg.sv ***
package lss_pkg;

   localparam int CLK_MHZ = 40;
   localparam int CNT_W = 12;
   localparam int NOUT = 6;
   localparam int WORD_W = 8;

   localparam int MODE_TIME_NS = 10000;
   localparam int POR_TIME_NS = 40000;
   localparam int FAULT_FILTER_TIME_NS = 20000;
   localparam int RETRY_OFF_TIME_NS = 100000;

   // least times: round up to whole cycles
   function automatic int cyc_from_ns(input int ns);
      cyc_from_ns = (ns * CLK_MHZ + 999) / 1000;
   endfunction : cyc_from_ns

   localparam logic [CNT_W-1:0] MODE_CYC = CNT_W'(cyc_from_ns(MODE_TIME_NS));
   localparam logic [CNT_W-1:0] POR_CYC = CNT_W'(cyc_from_ns(POR_TIME_NS));
   localparam logic [CNT_W-1:0] FILT_CYC = CNT_W'(cyc_from_ns(FAULT_FILTER_TIME_NS));
   localparam logic [CNT_W-1:0] RETRY_CYC = CNT_W'(cyc_from_ns(RETRY_OFF_TIME_NS));

   localparam int SLEEP_BIT = 7;
   localparam logic [WORD_W-1:0] CMD_RST = 8'h80;
   // synchroniser order {mode_mid, par_in[2:0], chip_activate_n, cs_n}
   localparam logic [5:0] SYNC_RST = 6'h03;
   localparam int SY_CS = 0;
   localparam int SY_EN = 1;
   localparam int SY_PAR = 2;
   localparam int SY_MID = 5;
   localparam logic [1:0] RESP_PAD = 2'h0;

   typedef enum logic {
      LSS_CH_WATCH = 1'b0,
      LSS_CH_RETRY = 1'b1
   } lss_chan_t;

endpackage : lss_pkg

// *** verilog/lss_spi_link.sv ***
`timescale 1ns/10ps
module lss_spi_link (
   input wire logic sclk_i,
   input wire logic arst_n_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic [7:0] resp_i,
   output logic [7:0] rx_o,
   output logic so_o,
   output logic so_oe_o
);

   logic [7:0] rx_q;
   logic [7:0] rx_d;
   logic [2:0] nf_q;
   logic [2:0] nf_d;
   logic fall_q;
   logic fall_d;
   logic so_q;
   logic so_d;
   logic [7:0] tx_w;
   logic frame_rst_n;

   // the frame's own select ends the falling-edge state; no sclk edge is assumed after it
   assign frame_rst_n = arst_n_i & ~cs_n_i;

   always_comb begin
      rx_d = rx_q;
      if (!cs_n_i) begin
         rx_d = {rx_q[6:0], si_i};
      end
   end

   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_q <= 8'h00;
      end else begin
         rx_q <= rx_d;
      end
   end

   always_comb begin
      tx_w = resp_i << (nf_q + 3'h1);
      fall_d = 1'b1;
      nf_d = (nf_q == 3'h7) ? nf_q : nf_q + 3'h1;
      // after eight response bits the oldest received bit follows: daisy chain
      so_d = (nf_q == 3'h7) ? rx_q[7] : tx_w[7];
   end

   always_ff @(negedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         nf_q <= 3'h0;
         fall_q <= 1'b0;
         so_q <= 1'b0;
      end else begin
         nf_q <= nf_d;
         fall_q <= fall_d;
         so_q <= so_d;
      end
   end

   assign rx_o = rx_q;
   // before the first falling edge the frozen response bit 7 stands on the line
   assign so_o = fall_q ? so_q : resp_i[7];
   assign so_oe_o = ~cs_n_i;

endmodule : lss_spi_link

// *** verilog/lss_core.sv ***
`timescale 1ns/10ps
module lss_core (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic chip_activate_n_i,
   input wire logic [2:0] par_in_i,
   input wire logic mode_mid_i,
   input wire logic [5:0] oc_flag_i,
   input wire logic [5:0] ol_flag_i,
   input wire logic ovp_flag_i,
   input wire logic vpwr_gnd_i,
   output logic [5:0] out_o,
   output logic pulldown_dis_o,
   output logic dual_mode_o,
   output logic so_o,
   output logic so_oe_o
);

   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic cs_prev_q;
   logic en_prev_q;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic asleep_q;
   logic asleep_d;
   logic por_q;
   logic por_d;
   logic [lss_pkg::CNT_W-1:0] por_cnt_q;
   logic [lss_pkg::CNT_W-1:0] por_cnt_d;
   logic [lss_pkg::CNT_W-1:0] mode_cnt_q;
   logic [lss_pkg::CNT_W-1:0] mode_cnt_d;
   logic dual_q;
   logic dual_d;
   logic [7:0] resp_q;
   logic [7:0] resp_d;
   logic [7:0] rx_w;

   logic [5:0] out_q;
   logic [5:0] out_d;
   logic [5:0] fault_q;
   logic [5:0] fault_d;
   logic pd_dis_q;
   logic pd_dis_d;
   lss_pkg::lss_chan_t ch_st_q [6];
   lss_pkg::lss_chan_t ch_st_d [6];
   logic [lss_pkg::CNT_W-1:0] ch_cnt_q [6];
   logic [lss_pkg::CNT_W-1:0] ch_cnt_d [6];

   logic cs_s;
   logic en_s;
   logic mid_s;
   logic [2:0] par_s;
   logic cs_rise;
   logic en_rise;
   logic en_fall;
   logic sleep_req;
   logic ovp_blk;
   logic block;
   logic det_en;
   logic grp_a;
   logic grp_b;
   logic [2:0] par_ok;
   logic [5:0] cmd_ok;
   logic [5:0] dem;

   lss_spi_link u_link (
      .sclk_i(sclk_i),
      .arst_n_i(arst_n_i),
      .cs_n_i(cs_n_i),
      .si_i(si_i),
      .resp_i(resp_q),
      .rx_o(rx_w),
      .so_o(so_o),
      .so_oe_o(so_oe_o)
   );

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync1_q <= lss_pkg::SYNC_RST;
         sync2_q <= lss_pkg::SYNC_RST;
      end else begin
         sync1_q <= {mode_mid_i, par_in_i, chip_activate_n_i, cs_n_i};
         sync2_q <= sync1_q;
      end
   end

   assign cs_s = sync2_q[lss_pkg::SY_CS];
   assign en_s = sync2_q[lss_pkg::SY_EN];
   assign mid_s = sync2_q[lss_pkg::SY_MID];
   assign par_s = sync2_q[lss_pkg::SY_PAR +: 3];
   assign cs_rise = cs_s & ~cs_prev_q;
   assign en_rise = en_s & ~en_prev_q;
   assign en_fall = ~en_s & en_prev_q;
   assign sleep_req = en_s & cmd_q[lss_pkg::SLEEP_BIT];

   // control: command word, sleep, dead time, mode select, response snapshot
   always_comb begin
      cmd_d = cmd_q;
      asleep_d = asleep_q;
      por_d = por_q;
      por_cnt_d = por_cnt_q;
      mode_cnt_d = mode_cnt_q;
      dual_d = dual_q;
      resp_d = resp_q;
      // rx is quiet while select is high, so it is safe to take across here
      if (cs_rise && !asleep_q) begin
         cmd_d = rx_w;
      end
      // counting comes first so a wake during the power-up run restarts the full dead time
      if (por_q) begin
         por_cnt_d = por_cnt_q + 12'h001;
         if (por_cnt_q == lss_pkg::POR_CYC - 12'h001) begin
            por_d = 1'b0;
         end
      end
      if (asleep_q) begin
         cmd_d = 8'h00;
         if (en_fall) begin
            asleep_d = 1'b0;
            por_d = 1'b1;
            por_cnt_d = '0;
         end
      end else if (en_rise && cmd_q[lss_pkg::SLEEP_BIT]) begin
         asleep_d = 1'b1;
      end
      if (mid_s) begin
         if (mode_cnt_q == lss_pkg::MODE_CYC) begin
            dual_d = 1'b1;
         end else begin
            mode_cnt_d = mode_cnt_q + 12'h001;
         end
      end else begin
         mode_cnt_d = '0;
         dual_d = 1'b0;
      end
      // frozen during a frame so the link shifts a stable word
      if (cs_s) begin
         resp_d = {lss_pkg::RESP_PAD, fault_q};
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_prev_q <= 1'b1;
         en_prev_q <= 1'b1;
         cmd_q <= lss_pkg::CMD_RST;
         asleep_q <= 1'b1;
         por_q <= 1'b1;
         por_cnt_q <= '0;
         mode_cnt_q <= '0;
         dual_q <= 1'b0;
         resp_q <= 8'h00;
      end else begin
         cs_prev_q <= cs_s;
         en_prev_q <= en_s;
         cmd_q <= cmd_d;
         asleep_q <= asleep_d;
         por_q <= por_d;
         por_cnt_q <= por_cnt_d;
         mode_cnt_q <= mode_cnt_d;
         dual_q <= dual_d;
         resp_q <= resp_d;
      end
   end

   // outputs and per-output fault filters
   always_comb begin
      ovp_blk = ovp_flag_i & ~vpwr_gnd_i;
      block = por_q | asleep_q | sleep_req | ovp_blk;
      det_en = ~asleep_q & ~sleep_req;
      par_ok = sleep_req ? 3'h0 : par_s;
      cmd_ok = en_s ? 6'h00 : cmd_q[5:0];
      grp_a = par_ok[0] | (cmd_ok[0] & cmd_ok[4] & cmd_ok[5]);
      grp_b = par_ok[1] | (cmd_ok[1] & cmd_ok[2] & cmd_ok[3]);
      if (dual_q) begin
         dem = {grp_a, grp_a, grp_b, grp_b, grp_b, grp_a};
      end else begin
         dem = {cmd_ok[5:3], par_ok | cmd_ok[2:0]};
      end
      pd_dis_d = sleep_req | asleep_q;
      fault_d = fault_q;
      // a set in the clearing cycle still lands
      if (cs_rise || asleep_q) begin
         fault_d = 6'h00;
      end
      for (int i = 0; i < lss_pkg::NOUT; i++) begin
         ch_st_d[i] = ch_st_q[i];
         ch_cnt_d[i] = ch_cnt_q[i];
         out_d[i] = ~block & dem[i] & (ch_st_q[i] == lss_pkg::LSS_CH_WATCH);
         case (ch_st_q[i])
            lss_pkg::LSS_CH_WATCH: begin
               if (det_en && (out_q[i] ? oc_flag_i[i] : ol_flag_i[i])) begin
                  ch_cnt_d[i] = ch_cnt_q[i] + 12'h001;
                  if (ch_cnt_q[i] == lss_pkg::FILT_CYC - 12'h001) begin
                     fault_d[i] = 1'b1;
                     ch_cnt_d[i] = '0;
                     if (out_q[i]) begin
                        ch_st_d[i] = lss_pkg::LSS_CH_RETRY;
                     end
                  end
               end else begin
                  ch_cnt_d[i] = '0;
               end
            end
            lss_pkg::LSS_CH_RETRY: begin
               ch_cnt_d[i] = ch_cnt_q[i] + 12'h001;
               if (ch_cnt_q[i] == lss_pkg::RETRY_CYC - 12'h001) begin
                  ch_cnt_d[i] = '0;
                  ch_st_d[i] = lss_pkg::LSS_CH_WATCH;
               end
            end
            default: begin
               ch_st_d[i] = lss_pkg::LSS_CH_WATCH;
               ch_cnt_d[i] = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         out_q <= 6'h00;
         fault_q <= 6'h00;
         pd_dis_q <= 1'b0;
         for (int i = 0; i < lss_pkg::NOUT; i++) begin
            ch_st_q[i] <= lss_pkg::LSS_CH_WATCH;
            ch_cnt_q[i] <= '0;
         end
      end else begin
         out_q <= out_d;
         fault_q <= fault_d;
         pd_dis_q <= pd_dis_d;
         for (int i = 0; i < lss_pkg::NOUT; i++) begin
            ch_st_q[i] <= ch_st_d[i];
            ch_cnt_q[i] <= ch_cnt_d[i];
         end
      end
   end

   assign out_o = out_q;
   assign pulldown_dis_o = pd_dis_q;
   assign dual_mode_o = dual_q;

   property p_hex_upper;
      @(posedge clock_i) disable iff (!arst_n_i)
      (!dual_q && !block && !en_s && ch_st_q[3] == lss_pkg::LSS_CH_WATCH) |=> (out_q[3] == $past(cmd_q[3]));
   endproperty
   a_hex_upper: assert property (p_hex_upper) else $error("hex out_3 does not follow command bit 3");

   property p_hex_or;
      @(posedge clock_i) disable iff (!arst_n_i)
      (!dual_q && !block && par_s[0] && ch_st_q[0] == lss_pkg::LSS_CH_WATCH) |=> out_q[0];
   endproperty
   a_hex_or: assert property (p_hex_or) else $error("hex out_0 not on with par_in_0 high");

   property p_dual_a;
      @(posedge clock_i) disable iff (!arst_n_i)
      (dual_q && !block && !en_s && cmd_q[0] && cmd_q[4] && cmd_q[5] && ch_st_q[0] == lss_pkg::LSS_CH_WATCH
       && ch_st_q[4] == lss_pkg::LSS_CH_WATCH && ch_st_q[5] == lss_pkg::LSS_CH_WATCH)
      |=> (out_q[0] && out_q[4] && out_q[5]);
   endproperty
   a_dual_a: assert property (p_dual_a) else $error("dual group a not on from command");

   property p_dual_b;
      @(posedge clock_i) disable iff (!arst_n_i)
      (dual_q && !block && par_s[1] && ch_st_q[1] == lss_pkg::LSS_CH_WATCH
       && ch_st_q[2] == lss_pkg::LSS_CH_WATCH && ch_st_q[3] == lss_pkg::LSS_CH_WATCH)
      |=> (out_q[1] && out_q[2] && out_q[3]);
   endproperty
   a_dual_b: assert property (p_dual_b) else $error("dual group b not on from par_in_1");

   property p_mode;
      @(posedge clock_i) disable iff (!arst_n_i)
      $rose(dual_q) |-> ($past(mode_cnt_q) == lss_pkg::MODE_CYC && $past(mid_s));
   endproperty
   a_mode: assert property (p_mode) else $error("dual mode entered before mid level held");

   property p_retry_off;
      @(posedge clock_i) disable iff (!arst_n_i)
      (ch_st_q[0] == lss_pkg::LSS_CH_RETRY) |=> !out_q[0];
   endproperty
   a_retry_off: assert property (p_retry_off) else $error("output on during retry off time");

   property p_sleep_pd;
      @(posedge clock_i) disable iff (!arst_n_i)
      (sleep_req || asleep_q) |=> (pulldown_dis_o && out_q == 6'h00);
   endproperty
   a_sleep_pd: assert property (p_sleep_pd) else $error("pull-downs not disabled or outputs on in sleep");

   property p_cmd_load;
      @(posedge clock_i) disable iff (!arst_n_i)
      (cs_rise && !asleep_q) |=> (cmd_q == $past(rx_w));
   endproperty
   a_cmd_load: assert property (p_cmd_load) else $error("command not loaded at select rise");

   property p_fault_clr;
      @(posedge clock_i) disable iff (!arst_n_i)
      cs_rise |=> ((fault_q & ~$past(oc_flag_i | ol_flag_i)) == 6'h00);
   endproperty
   a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared at select rise");

   property p_por;
      @(posedge clock_i) disable iff (!arst_n_i)
      por_q |=> (out_q == 6'h00);
   endproperty
   a_por: assert property (p_por) else $error("output on during dead time");

   property p_asleep;
      @(posedge clock_i) disable iff (!arst_n_i)
      asleep_q ##1 asleep_q |-> (cmd_q == 8'h00 && fault_q == 6'h00);
   endproperty
   a_asleep: assert property (p_asleep) else $error("state not cleared in sleep");

   property p_ovp;
      @(posedge clock_i) disable iff (!arst_n_i)
      (ovp_flag_i && !vpwr_gnd_i) |=> (out_q == 6'h00);
   endproperty
   a_ovp: assert property (p_ovp) else $error("output on during overvoltage");

endmodule : lss_core

// *** bench/lss_host_model.sv ***
`timescale 1ns/10ps
module lss_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   // sclk stands still low between frames, si rests at its pull-down level
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // one frame, msb first; dz is what shows after the eighth falling edge
   task automatic xfer(input logic [7:0] cmd, output logic [7:0] rsp, output logic dz);
      // keep the select edge clear of the core clock edge that started the call
      #5;
      cs_n_o = 1'b0;
      // long lead so the response snapshot has crossed before the first edge
      #150;
      for (int k = 7; k >= 0; k--) begin
         si_o = cmd[k];
         #62.5;
         sclk_o = 1'b1;
         rsp[k] = so_oe_i ? so_i : 1'bz;
         #62.5;
         sclk_o = 1'b0;
      end
      #30;
      dz = so_oe_i ? so_i : 1'bz;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      #200;
   endtask : xfer
endmodule : lss_host_model

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
   logic clock_i, arst_n_i, sclk, cs_n, si, act_n, mid, ovp, vgnd;
   logic [2:0] par;
   logic [5:0] oc, ol, out;
   logic pd_dis, dual, so, so_oe, dz;
   logic [7:0] rsp;
   int err_total = 0;
   int n_tests = 0;

   lss_core i_lss_core (.clock_i(clock_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
      .chip_activate_n_i(act_n), .par_in_i(par), .mode_mid_i(mid), .oc_flag_i(oc), .ol_flag_i(ol),
      .ovp_flag_i(ovp), .vpwr_gnd_i(vgnd), .out_o(out), .pulldown_dis_o(pd_dis), .dual_mode_o(dual),
      .so_o(so), .so_oe_o(so_oe));
   lss_host_model i_lss_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask : cyc

   // step past the edge so the registered outputs have settled
   task automatic chk_out(input logic [5:0] exp);
      #1;
      chk({2'h0, out}, {2'h0, exp});
   endtask : chk_out

   // the command needs a few core cycles to cross after chip select rises
   task automatic frame(input logic [7:0] cmd);
      i_lss_host_model.xfer(cmd, rsp, dz);
      cyc(6);
   endtask : frame

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #1ms;
      err_total++;
      tally_and_finish();
   end

   initial begin
      arst_n_i = 1'b0;
      act_n = 1'b0;
      par = 3'h0;
      mid = 1'b0;
      ovp = 1'b0;
      vgnd = 1'b0;
      oc = 6'h00;
      ol = 6'h00;
      cyc(3);
      arst_n_i <= 1'b1;
      par <= 3'h7;
      cyc(1590);
      chk_out(6'h00);
      chk({7'h0, so_oe}, 8'h00);
      cyc(20);
      chk_out(6'h07);
      frame(8'hb8);
      chk_out(6'h3f);
      chk(rsp, 8'h00);
      chk({7'h0, dz}, 8'h01);
      cyc(1);
      par <= 3'h0;
      cyc(3);
      chk_out(6'h38);
      cyc(1);
      par <= 3'h2;
      frame(8'h05);
      chk_out(6'h07);
      chk({7'h0, dz}, 8'h00);
      frame(8'h3f);
      cyc(1);
      act_n <= 1'b1;
      par <= 3'h1;
      cyc(6);
      chk_out(6'h01);
      cyc(1);
      act_n <= 1'b0;
      par <= 3'h0;
      // not asleep, so no dead time on the way back
      cyc(6);
      chk_out(6'h3f);
      cyc(1);
      ovp <= 1'b1;
      cyc(3);
      chk_out(6'h00);
      cyc(1);
      vgnd <= 1'b1;
      cyc(3);
      chk_out(6'h3f);
      cyc(1);
      ovp <= 1'b0;
      vgnd <= 1'b0;
      frame(8'h31);
      cyc(1);
      mid <= 1'b1;
      cyc(400);
      #1;
      chk({7'h0, dual}, 8'h00);
      cyc(5);
      #1;
      chk({7'h0, dual}, 8'h01);
      chk_out(6'h31);
      frame(8'h0e);
      chk_out(6'h0e);
      frame(8'h06);
      chk_out(6'h00);
      cyc(1);
      par <= 3'h2;
      cyc(5);
      chk_out(6'h0e);
      cyc(1);
      par <= 3'h1;
      cyc(5);
      chk_out(6'h31);
      cyc(1);
      par <= 3'h0;
      mid <= 1'b0;
      cyc(5);
      #1;
      chk({7'h0, dual}, 8'h00);
      frame(8'h01);
      cyc(1);
      oc <= 6'h01;
      cyc(790);
      chk_out(6'h01);
      cyc(30);
      chk_out(6'h00);
      cyc(3900);
      chk_out(6'h00);
      cyc(200);
      chk_out(6'h01);
      cyc(1);
      oc <= 6'h00;
      ol <= 6'h08;
      cyc(900);
      frame(8'h01);
      chk(rsp, 8'h09);
      frame(8'h01);
      chk(rsp, 8'h00);
      cyc(900);
      frame(8'h01);
      chk(rsp, 8'h08);
      cyc(1);
      ol <= 6'h00;
      frame(8'h81);
      cyc(1);
      act_n <= 1'b1;
      par <= 3'h7;
      cyc(6);
      chk_out(6'h00);
      chk({7'h0, pd_dis}, 8'h01);
      // a frame while asleep must leave the command cleared
      frame(8'h3f);
      cyc(1);
      act_n <= 1'b0;
      cyc(1590);
      chk_out(6'h00);
      cyc(20);
      chk_out(6'h07);
      chk({7'h0, pd_dis}, 8'h00);
      frame(8'h00);
      chk(rsp, 8'h00);
      tally_and_finish();
   end
endmodule : tb
